// file: pcicsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcicsr_cfg.svh"
//Behaviour
//- upper identifier half shows loaded device ident, host writes ignored
//- lower identifier half shows loaded maker ident, read only
//- parity error bit sets on any detected parity error, resets zero
//- system error bit sets whenever system error output driven
//- master abort bit sets when own master transaction master-aborted
//- target abort bit sets when own master transaction target-aborted
//- devsel timing field reads constant medium, ignores writes
//- data parity bit sets only if master, parity enabled, PERR seen
//- fast back-to-back bit always reads one
//- new capabilities bit mirrors capability bit of host config register
//- system error enable plus address parity error drives system error
//- parity enable off: parity error bit still sets, no host flag; on, flags host system error
//- master enable resets zero; zero blocks master transfers
//- memory enable resets zero; zero blocks memory decoding
//- identifiers reload from serial memory after each reset release
//- hardware reset restores defaults
//- byte, word and doubleword writes honour byte enables, reads ignore them
module pcicsr_regs
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CFG_RD,
	input  wire logic        CFG_WR,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic [3:0]  CFG_BE,
	input  wire logic [31:0] CFG_WDATA,
	output logic [31:0]      CFG_RDATA,
	input  wire logic        EE_VALID,
	input  wire logic [15:0] EE_DEVICE,
	input  wire logic [15:0] EE_MAKER,
	input  wire logic        CAP_LIST_CFG,
	input  wire logic        PARITY_ERR,
	input  wire logic        ADDR_PARITY_ERR,
	input  wire logic        PERR_SEEN,
	input  wire logic        AS_MASTER,
	input  wire logic        MASTER_ABORT,
	input  wire logic        TARGET_ABORT,
	output logic             SERR_OUT,
	output logic             HOST_SERR_SET,
	output logic             MASTER_ENABLE,
	output logic             MEMORY_ENABLE
);
	pcicsr_pkg::pcicsr_state_t s;
	pcicsr_pkg::pcicsr_state_t next_s;
	logic [15:0] dev_id;
	logic [15:0] mak_id;
	logic [31:0] word;
	logic [31:0] bmask;
	logic [31:0] clr;
	logic        serr_now;

	pcicsr_ident_load u_ld
	(
		.clk          (CLK),
		.rst_n        (RST_N),
		.ee_valid     (EE_VALID),
		.ee_device    (EE_DEVICE),
		.ee_maker     (EE_MAKER),
		.device_ident (dev_id),
		.maker_ident  (mak_id)
	);

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// ************************************************
	// read view
	// ************************************************
	always_comb
	begin
		word = `PCICSR_ZERO32;
		word[`PCICSR_BIT_PERR_DET] = s.perr_det;
		word[`PCICSR_BIT_SERR_SIG] = s.serr_sig;
		word[`PCICSR_BIT_MABORT] = s.mabort;
		word[`PCICSR_BIT_TABORT] = s.tabort;
		word[`PCICSR_DEVSEL_HI:`PCICSR_DEVSEL_LO] = `PCICSR_DEVSEL_MEDIUM;
		word[`PCICSR_BIT_DPR] = s.dpr;
		word[`PCICSR_BIT_FB2B] = 1'b1;
		word[`PCICSR_BIT_NEWCAP] = CAP_LIST_CFG;
		word[`PCICSR_BIT_SERR_EN] = s.serr_en;
		word[`PCICSR_BIT_PERR_EN] = s.perr_en;
		word[`PCICSR_BIT_MASTER_EN] = s.master_en;
		word[`PCICSR_BIT_MEM_EN] = s.mem_en;
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		next_s = s;
		bmask = be_mask(CFG_BE);
		clr = `PCICSR_ZERO32;
		serr_now = s.serr_en && ADDR_PARITY_ERR;
		next_s.device_ident = dev_id;
		next_s.maker_ident = mak_id;
		if (CFG_WR && CFG_ADDR == `PCICSR_OFF_CMDSTAT)
		begin
			next_s.serr_en = bmask[`PCICSR_BIT_SERR_EN]
				? CFG_WDATA[`PCICSR_BIT_SERR_EN] : s.serr_en;
			next_s.perr_en = bmask[`PCICSR_BIT_PERR_EN]
				? CFG_WDATA[`PCICSR_BIT_PERR_EN] : s.perr_en;
			next_s.master_en = bmask[`PCICSR_BIT_MASTER_EN]
				? CFG_WDATA[`PCICSR_BIT_MASTER_EN] : s.master_en;
			next_s.mem_en = bmask[`PCICSR_BIT_MEM_EN]
				? CFG_WDATA[`PCICSR_BIT_MEM_EN] : s.mem_en;
			// status bits clear by writing one
			clr = CFG_WDATA & bmask;
		end
		if (clr[`PCICSR_BIT_PERR_DET])
			next_s.perr_det = 1'b0;
		if (clr[`PCICSR_BIT_SERR_SIG])
			next_s.serr_sig = 1'b0;
		if (clr[`PCICSR_BIT_MABORT])
			next_s.mabort = 1'b0;
		if (clr[`PCICSR_BIT_TABORT])
			next_s.tabort = 1'b0;
		if (clr[`PCICSR_BIT_DPR])
			next_s.dpr = 1'b0;
		// set wins over a same-cycle clear
		// parity error set
		if (PARITY_ERR || ADDR_PARITY_ERR)
			next_s.perr_det = 1'b1;
		if (serr_now)
			next_s.serr_sig = 1'b1;
		if (MASTER_ABORT && AS_MASTER)
			next_s.mabort = 1'b1;
		if (TARGET_ABORT && AS_MASTER)
			next_s.tabort = 1'b1;
		if (PERR_SEEN && AS_MASTER && s.master_en && s.perr_en)
			next_s.dpr = 1'b1;
		if (CFG_RD)
		begin
			case (CFG_ADDR)
				`PCICSR_OFF_IDENT:
					next_s.rdata = {s.device_ident, s.maker_ident};
				`PCICSR_OFF_CMDSTAT:
					next_s.rdata = word;
				default:
					next_s.rdata = `PCICSR_ZERO32;
			endcase
		end
	end

	// ************************************************
	// registers
	// ************************************************
	// hardware reset only
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign CFG_RDATA = s.rdata;
	assign SERR_OUT = serr_now;
	assign HOST_SERR_SET = s.perr_en && (PARITY_ERR || ADDR_PARITY_ERR);
	assign MASTER_ENABLE = s.master_en;
	assign MEMORY_ENABLE = s.mem_en;

	// ************************************************
	// checks
	// ************************************************
	perr_sticky_a: assert property (@(posedge CLK) disable iff (!RST_N)
		PARITY_ERR |=> s.perr_det)
		else $error("parity error not recorded");
	serr_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
		SERR_OUT |=> s.serr_sig)
		else $error("system error not recorded");
	mabort_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(MASTER_ABORT && AS_MASTER) |=> s.mabort)
		else $error("master abort not recorded");
	tabort_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(TARGET_ABORT && AS_MASTER) |=> s.tabort)
		else $error("target abort not recorded");
	dpr_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(s.dpr) |-> $past(PERR_SEEN && AS_MASTER && s.perr_en))
		else $error("data parity set without cause");
	serr_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
		SERR_OUT |-> (s.serr_en && ADDR_PARITY_ERR))
		else $error("system error without enable");
	cmd_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(CFG_RD && CFG_ADDR == `PCICSR_OFF_CMDSTAT) |=>
		(CFG_RDATA[`PCICSR_DEVSEL_HI:`PCICSR_DEVSEL_LO]
			== `PCICSR_DEVSEL_MEDIUM && CFG_RDATA[`PCICSR_BIT_FB2B]
			&& CFG_RDATA[`PCICSR_BIT_RSVD27] == 1'b0))
		else $error("fixed status fields wrong");
	ident_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(CFG_RD && CFG_ADDR == `PCICSR_OFF_IDENT) |=>
		CFG_RDATA == $past({s.device_ident, s.maker_ident}))
		else $error("identifier read wrong");
	mem_en_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(CFG_WR && CFG_ADDR == `PCICSR_OFF_CMDSTAT && CFG_BE[0]) |=>
		MEMORY_ENABLE == $past(CFG_WDATA[`PCICSR_BIT_MEM_EN]))
		else $error("memory enable not written");
endmodule
`default_nettype wire

// file: pcicsr_cfg.svh
`ifndef PCICSR_CFG_SVH
`define PCICSR_CFG_SVH
`define PCICSR_OFF_IDENT     8'h00
`define PCICSR_OFF_CMDSTAT   8'h04
`define PCICSR_BIT_PERR_DET  31
`define PCICSR_BIT_SERR_SIG  30
`define PCICSR_BIT_MABORT    29
`define PCICSR_BIT_TABORT    28
`define PCICSR_BIT_RSVD27    27
`define PCICSR_DEVSEL_HI     26
`define PCICSR_DEVSEL_LO     25
`define PCICSR_DEVSEL_MEDIUM 2'h1
`define PCICSR_BIT_DPR       24
`define PCICSR_BIT_FB2B      23
`define PCICSR_BIT_NEWCAP    20
`define PCICSR_BIT_SERR_EN   8
`define PCICSR_BIT_PERR_EN   6
`define PCICSR_BIT_MASTER_EN 2
`define PCICSR_BIT_MEM_EN    1
`define PCICSR_CFG_BIT_CAP   19
`define PCICSR_HOST_BIT_SERR 13
`define PCICSR_ZERO32        32'h0000_0000
`define PCICSR_ZERO16        16'h0000
`endif

// file: pcicsr_pkg.sv
package pcicsr_pkg;
	typedef struct packed {
		logic [15:0] device_ident;
		logic [15:0] maker_ident;
		logic        perr_det;
		logic        serr_sig;
		logic        mabort;
		logic        tabort;
		logic        dpr;
		logic        serr_en;
		logic        perr_en;
		logic        master_en;
		logic        mem_en;
		logic [31:0] rdata;
	} pcicsr_state_t;
	typedef struct packed {
		logic        seen;
		logic        load_pend;
		logic [15:0] device_ident;
		logic [15:0] maker_ident;
	} pcicsr_ld_t;
endpackage

// file: pcicsr_ident_load.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcicsr_cfg.svh"
// latches identifiers once after each reset release, on the first clock with ee_valid from the second clock on
module pcicsr_ident_load
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ee_valid,
	input  wire logic [15:0] ee_device,
	input  wire logic [15:0] ee_maker,
	output logic [15:0]      device_ident,
	output logic [15:0]      maker_ident
);
	pcicsr_pkg::pcicsr_ld_t s;
	pcicsr_pkg::pcicsr_ld_t next_s;

	always_comb
	begin
		next_s = s;
		if (!s.seen)
		begin
			next_s.seen = 1'b1;
			next_s.load_pend = 1'b1;
		end
		if (s.load_pend && ee_valid)
		begin
			next_s.device_ident = ee_device;
			next_s.maker_ident = ee_maker;
			next_s.load_pend = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign device_ident = s.device_ident;
	assign maker_ident = s.maker_ident;
endmodule
`default_nettype wire

// file: pcicsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// host bridge model
// ********************
module pcicsr_host_model
(
	input  wire logic        CLK,
	input  wire logic [31:0] CFG_RDATA,
	output logic             CFG_RD,
	output logic             CFG_WR,
	output logic [7:0]       CFG_ADDR,
	output logic [3:0]       CFG_BE,
	output logic [31:0]      CFG_WDATA
);
	initial
	begin
		{CFG_RD, CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} = 46'h0;
	end
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge CLK);
		{CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} <= {1'h1, a, be, d};
		@(posedge CLK);
		CFG_WR <= 1'h0;
		// released lanes must not keep showing the last data
		CFG_WDATA <= ~d;
	endtask
	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge CLK);
		{CFG_RD, CFG_ADDR, CFG_BE} <= {1'h1, a, 4'hf};
		@(posedge CLK);
		CFG_RD <= 1'h0;
		// one spare edge: read data holds until the next read
		@(posedge CLK);
		#1 d = CFG_RDATA;
	endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// config header bench
// ********************
module testbench;
	logic        CLK, RST_N, EE_VALID, CAP_LIST_CFG, CFG_RD, CFG_WR;
	logic        PARITY_ERR, ADDR_PARITY_ERR, PERR_SEEN, AS_MASTER;
	logic        MASTER_ABORT, TARGET_ABORT, SERR_OUT, HOST_SERR_SET;
	logic        MASTER_ENABLE, MEMORY_ENABLE;
	logic [7:0]  CFG_ADDR;
	logic [3:0]  CFG_BE;
	logic [15:0] EE_DEVICE, EE_MAKER;
	logic [31:0] CFG_WDATA, CFG_RDATA, rd;
	int          mismatches, check_count;

	pcicsr_regs i_dut (.*);
	pcicsr_host_model i_host (.*);

	always #25 CLK = ~CLK;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		i_host.cfg_read(a, rd);
		chk(rd, exp);
	endtask
	// drives one cycle of events, checks the combinational error outputs
	task automatic pulse(input logic [5:0] v, input logic [1:0] exp);
		@(posedge CLK);
		{PARITY_ERR, ADDR_PARITY_ERR, PERR_SEEN, AS_MASTER, MASTER_ABORT,
			TARGET_ABORT} <= v;
		#1 chk({30'h0, SERR_OUT, HOST_SERR_SET}, {30'h0, exp});
		@(posedge CLK);
		{PARITY_ERR, ADDR_PARITY_ERR, PERR_SEEN, AS_MASTER, MASTER_ABORT,
			TARGET_ABORT} <= 6'h0;
	endtask
	task automatic do_reset(input logic [15:0] dev, input logic [15:0] mak,
		input logic cap);
		RST_N <= 1'h0;
		EE_VALID <= 1'h0;
		{EE_DEVICE, EE_MAKER, CAP_LIST_CFG} <= {dev, mak, cap};
		repeat (8) @(posedge CLK);
		RST_N <= 1'h1;
		// valid arrives late: the loader must wait for it after release
		repeat (2) @(posedge CLK);
		EE_VALID <= 1'h1;
		repeat (3) @(posedge CLK);
	endtask

	task automatic t_defaults;
		do_reset(16'h1234, 16'h5678, 1'h1);
		rd_chk(8'h00, 32'h1234_5678);
		rd_chk(8'h04, 32'h0290_0000);
		chk({30'h0, MASTER_ENABLE, MEMORY_ENABLE}, 32'h0000_0000);
		$display("t_defaults done");
	endtask
	task automatic t_write;
		i_host.cfg_write(8'h04, 4'hf, 32'hffff_ffff);
		rd_chk(8'h04, 32'h0290_0146);
		chk({30'h0, MASTER_ENABLE, MEMORY_ENABLE}, 32'h0000_0003);
		i_host.cfg_write(8'h00, 4'hf, 32'hffff_ffff);
		rd_chk(8'h00, 32'h1234_5678);
		rd_chk(8'h08, 32'h0000_0000);
		$display("t_write done");
	endtask
	task automatic t_lanes;
		i_host.cfg_write(8'h04, 4'h2, 32'h0000_0000);
		rd_chk(8'h04, 32'h0290_0046);
		i_host.cfg_write(8'h04, 4'h1, 32'h0000_0000);
		rd_chk(8'h04, 32'h0290_0000);
		i_host.cfg_write(8'h04, 4'h3, 32'h0000_0146);
		rd_chk(8'h04, 32'h0290_0146);
		$display("t_lanes done");
	endtask
	task automatic t_events;
		pulse(6'h10, 2'h3);
		pulse(6'h0f, 2'h0);
		rd_chk(8'h04, 32'hf390_0146);
		i_host.cfg_write(8'h04, 4'hc, 32'hffff_0000);
		rd_chk(8'h04, 32'h0290_0146);
		$display("t_events done");
	endtask
	task automatic t_disabled;
		i_host.cfg_write(8'h04, 4'hf, 32'h0000_0004);
		pulse(6'h30, 2'h0);
		pulse(6'h0e, 2'h0);
		rd_chk(8'h04, 32'ha290_0004);
		$display("t_disabled done");
	endtask
	task automatic t_reload;
		do_reset(16'h9abc, 16'hdef0, 1'h0);
		rd_chk(8'h00, 32'h9abc_def0);
		rd_chk(8'h04, 32'h0280_0000);
		chk({30'h0, MASTER_ENABLE, MEMORY_ENABLE}, 32'h0000_0000);
		$display("t_reload done");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		CLK = 1'h0;
		{PARITY_ERR, ADDR_PARITY_ERR, PERR_SEEN, AS_MASTER, MASTER_ABORT,
			TARGET_ABORT} = 6'h0;
		mismatches = 0;
		check_count = 0;
		t_defaults();
		t_write();
		t_lanes();
		t_events();
		t_disabled();
		t_reload();
		wrap_up();
	end
endmodule
`default_nettype wire
